// >>> pdio_pkg.sv
// Package for the parallel digital I/O port: register map, field layout, reset values
`default_nettype none
package pdio_pkg;
	localparam int NUM_BYTES = 5;
	localparam int NUM_LINES = 40;
	localparam int MON_LINES = 15;
	localparam int STAT_PINS = 2;
	// Register offsets
	localparam logic [7:0] ADDR_DIR = 8'h00;
	localparam logic [7:0] ADDR_OUT_BASE = 8'h01;
	localparam logic [7:0] ADDR_IN_BASE = 8'h06;
	localparam logic [7:0] ADDR_OPOL_BASE = 8'h0B;
	localparam logic [7:0] ADDR_IPOL_BASE = 8'h10;
	localparam logic [7:0] ADDR_BITOP = 8'h15;
	localparam logic [7:0] ADDR_STR_CFG = 8'h16;
	localparam logic [7:0] ADDR_STR_OUT = 8'h17;
	localparam logic [7:0] ADDR_STR_IN = 8'h18;
	localparam logic [7:0] ADDR_CTRL = 8'h19;
	localparam logic [7:0] ADDR_MON_RISE = 8'h1A;
	localparam logic [7:0] ADDR_MON_FALL = 8'h1B;
	localparam logic [7:0] ADDR_MON_EN = 8'h1C;
	localparam logic [7:0] ADDR_MON_COND = 8'h1D;
	localparam logic [7:0] ADDR_MON_EVT = 8'h1E;
	localparam logic [7:0] ADDR_OPER = 8'h1F;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	// Bit operation field layout: [2:0] bit, [5:3] byte, [7:6] op
	localparam logic [1:0] BITOP_SET = 2'h1;
	localparam logic [1:0] BITOP_CLR = 2'h2;
	localparam logic [1:0] BITOP_PULSE = 2'h3;
	// Control register bits (write: commands, persistent fields)
	localparam int CTRL_STROBE = 0;
	localparam int CTRL_SAVE = 1;
	localparam int CTRL_DEFAULT = 2;
	localparam int CTRL_LOCK = 3;
	localparam int CTRL_STB_POL = 4;
	localparam int CTRL_HS_POL = 5;
	localparam int CTRL_TRANSP = 6;
	localparam int CTRL_WORD_SEP = 7;
	// String configuration: [4:0] output bytes, [9:5] input bytes, 10 out hs, 11 in hs
	localparam int STRCFG_OHS = 10;
	localparam int STRCFG_IHS = 11;
	// Reset values (factory defaults)
	localparam logic [NUM_BYTES-1:0] DIR_RST = 5'h00;
	localparam logic [11:0] STRCFG_RST = 12'h000;
	localparam logic [7:0] POL_RST = 8'h00;
	// Timing
	localparam int CLK_HZ = 50000000;
	localparam int PULSE_NS = 50000;
	localparam int PULSE_CYC = (PULSE_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int STROBE_NS = 1000;
	localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000)) / 1000;
endpackage : pdio_pkg
`default_nettype wire

// >>> pdio_port.sv
// Parallel digital I/O port: 5 bytes, bit/byte/string access, change monitor, restore
`default_nettype none
module pdio_port (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic self_test_ok_i,
	input wire logic [pdio_pkg::NUM_LINES-1:0] io_i,
	output logic [pdio_pkg::NUM_LINES-1:0] io_o,
	output logic [pdio_pkg::NUM_LINES-1:0] io_oe_o,
	input wire logic [pdio_pkg::STAT_PINS-1:0] stat_pin_i,
	output logic settled_o,
	output logic strobe_o,
	input wire logic hs_ack_i,
	output logic srq_o,
	input wire logic [pdio_pkg::NUM_LINES-1:0] nv_out_i,
	input wire logic [pdio_pkg::NUM_BYTES-1:0] nv_dir_i,
	output logic nv_save_o,
	output logic [pdio_pkg::NUM_LINES-1:0] nv_out_o,
	output logic [pdio_pkg::NUM_BYTES-1:0] nv_dir_o
);
	typedef enum logic [3:0] {
		PDIO_ST_BOOT = 4'h1,
		PDIO_ST_APPLY = 4'h2,
		PDIO_ST_RUN = 4'h4,
		PDIO_ST_WAIT = 4'h8
	} pdio_state_t;

	localparam int NB = pdio_pkg::NUM_BYTES;
	localparam int NL = pdio_pkg::NUM_LINES;
	localparam int ML = pdio_pkg::MON_LINES;

	pdio_state_t state_reg, state_next;
	logic [NB-1:0] dir_reg, dir_next;
	logic [NL-1:0] out_reg, out_next;
	logic [NL-1:0] opol_reg, opol_next;
	logic [NL-1:0] ipol_reg, ipol_next;
	logic [NL-1:0] pulse_mask_reg, pulse_mask_next;
	logic [15:0] pulse_cnt_reg, pulse_cnt_next;
	logic [11:0] strcfg_reg, strcfg_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [15:0] stb_cnt_reg, stb_cnt_next;
	logic stb_wait_reg, stb_wait_next;
	logic [ML-1:0] rise_reg, rise_next;
	logic [ML-1:0] fall_reg, fall_next;
	logic [ML+1:0] en_reg, en_next;
	logic [ML+1:0] evt_reg, evt_next;
	logic [ML-1:0] mon_prev_reg, mon_prev_next;
	logic [1:0] stat_prev_reg, stat_prev_next;
	logic [NL-1:0] strin_reg, strin_next;
	logic [31:0] rdata_reg, rdata_next;
	logic settled_reg, settled_next;
	logic srq_reg, srq_next;
	logic nv_save_reg, nv_save_next;
	logic [NL-1:0] drive_lvl;
	logic [NL-1:0] drive_oe;
	logic [ML-1:0] hit;
	logic [1:0] stat_hit;
	logic unlocked;
	logic strobe_active;
	logic hs_ack;

	assign unlocked = ~ctrl_reg[pdio_pkg::CTRL_LOCK];
	assign strobe_active = (stb_cnt_reg != 16'h0000);
	// Acknowledge is taken in its configured active level
	assign hs_ack = hs_ack_i ^ ctrl_reg[pdio_pkg::CTRL_HS_POL];

	genvar g;
	generate
		for (g = 0; g < NL; g++) begin : g_line
			// Lines float until the restored setup is applied
			assign drive_oe[g] = dir_reg[g/8] & (state_reg != PDIO_ST_BOOT);
			assign drive_lvl[g] = out_reg[g] ^ pulse_mask_reg[g];
		end
		for (g = 0; g < ML; g++) begin : g_mon
			assign hit[g] = (rise_reg[g] & io_i[g] & ~mon_prev_reg[g])
				| (fall_reg[g] & ~io_i[g] & mon_prev_reg[g]);
		end
	endgenerate
	assign stat_hit = stat_pin_i ^ stat_prev_reg;

	always_comb begin
		state_next = state_reg;
		dir_next = dir_reg;
		out_next = out_reg;
		opol_next = opol_reg;
		ipol_next = ipol_reg;
		pulse_mask_next = pulse_mask_reg;
		pulse_cnt_next = pulse_cnt_reg;
		strcfg_next = strcfg_reg;
		ctrl_next = ctrl_reg;
		stb_cnt_next = stb_cnt_reg;
		stb_wait_next = stb_wait_reg;
		rise_next = rise_reg;
		fall_next = fall_reg;
		en_next = en_reg;
		evt_next = evt_reg;
		mon_prev_next = io_i[ML-1:0];
		stat_prev_next = stat_pin_i;
		strin_next = strin_reg;
		rdata_next = 32'h0000_0000;
		settled_next = settled_reg;
		nv_save_next = 1'b0;

		case (state_reg)
			PDIO_ST_BOOT: begin
				if (self_test_ok_i) begin
					dir_next = nv_dir_i;
					out_next = nv_out_i;
					state_next = PDIO_ST_APPLY;
				end
			end
			PDIO_ST_APPLY: begin
				// Pins take the restored setup on the next edge
				state_next = PDIO_ST_WAIT;
			end
			PDIO_ST_WAIT: begin
				// Settled lags the pins by a cycle so loads see driven lines first
				state_next = PDIO_ST_RUN;
				settled_next = 1'b1;
			end
			PDIO_ST_RUN: ;
			default: state_next = PDIO_ST_BOOT;
		endcase

		// Pulse width timing
		if (pulse_cnt_reg != 16'h0000) begin
			pulse_cnt_next = pulse_cnt_reg - 16'h0001;
			if (pulse_cnt_reg == 16'h0001)
				pulse_mask_next = '0;
		end
		// Strobe timing; handshaked strobe holds until acknowledge
		if (strobe_active) begin
			if (stb_wait_reg) begin
				if (hs_ack) begin
					stb_cnt_next = 16'h0000;
					stb_wait_next = 1'b0;
				end
			end else begin
				stb_cnt_next = stb_cnt_reg - 16'h0001;
			end
		end

		// Event capture: set wins over clear
		if (rd_i && addr_i == pdio_pkg::ADDR_MON_EVT)
			evt_next = '0;
		if (state_reg == PDIO_ST_RUN)
			evt_next = evt_next | {stat_hit, hit};

		if (state_reg == PDIO_ST_RUN && wr_i) begin
			if (addr_i == pdio_pkg::ADDR_DIR) begin
				if (unlocked)
					dir_next = wdata_i[NB-1:0];
			end else if (addr_i >= pdio_pkg::ADDR_OUT_BASE &&
					addr_i < pdio_pkg::ADDR_IN_BASE) begin
				for (int b = 0; b < NB; b++) begin
					if (addr_i == pdio_pkg::ADDR_OUT_BASE + 8'(b)) begin
						out_next[b*8 +: 8] = wdata_i[7:0] ^ opol_reg[b*8 +: 8];
						dir_next[b] = 1'b1;
					end
				end
			end else if (addr_i >= pdio_pkg::ADDR_OPOL_BASE &&
					addr_i < pdio_pkg::ADDR_IPOL_BASE) begin
				for (int b = 0; b < NB; b++)
					if (unlocked && addr_i == pdio_pkg::ADDR_OPOL_BASE + 8'(b))
						opol_next[b*8 +: 8] = wdata_i[7:0];
			end else if (addr_i >= pdio_pkg::ADDR_IPOL_BASE &&
					addr_i < pdio_pkg::ADDR_BITOP) begin
				for (int b = 0; b < NB; b++)
					if (unlocked && addr_i == pdio_pkg::ADDR_IPOL_BASE + 8'(b))
						ipol_next[b*8 +: 8] = wdata_i[7:0];
			end else if (addr_i == pdio_pkg::ADDR_BITOP) begin
				// Bits [31:8] name extra lines 16 to 39 for a multi-line pulse
				if (wdata_i[5:3] < 3'(NB)) begin
					dir_next[wdata_i[5:3]] = 1'b1;
					case (wdata_i[7:6])
						pdio_pkg::BITOP_SET: out_next[{wdata_i[5:3], wdata_i[2:0]}] = 1'b1;
						pdio_pkg::BITOP_CLR: out_next[{wdata_i[5:3], wdata_i[2:0]}] = 1'b0;
						pdio_pkg::BITOP_PULSE: begin
							pulse_mask_next[{wdata_i[5:3], wdata_i[2:0]}] = 1'b1;
							pulse_mask_next[NL-1:16] = pulse_mask_next[NL-1:16]
								| wdata_i[31:8];
							pulse_cnt_next = 16'(pdio_pkg::PULSE_CYC);
						end
						default: ;
					endcase
				end
			end else if (addr_i == pdio_pkg::ADDR_STR_CFG) begin
				if (unlocked)
					strcfg_next = wdata_i[11:0];
			end else if (addr_i == pdio_pkg::ADDR_STR_OUT) begin
				// Latch every string byte; the strobe starts in the same cycle unless CTRL_TRANSP is set and bit 31 is clear
				for (int b = 0; b < NB; b++)
					if (strcfg_reg[b])
						out_next[b*8 +: 8] = wdata_i[8*(b%4) +: 8] ^ opol_reg[b*8 +: 8];
				if (!ctrl_reg[pdio_pkg::CTRL_TRANSP] || wdata_i[31]) begin
					stb_cnt_next = 16'(pdio_pkg::STROBE_CYC);
					stb_wait_next = strcfg_reg[pdio_pkg::STRCFG_OHS];
				end
			end else if (addr_i == pdio_pkg::ADDR_CTRL) begin
				if (wdata_i[pdio_pkg::CTRL_STROBE] && !strobe_active) begin
					stb_cnt_next = 16'(pdio_pkg::STROBE_CYC);
					stb_wait_next = 1'b0;
				end
				if (wdata_i[pdio_pkg::CTRL_SAVE])
					nv_save_next = 1'b1;
				if (wdata_i[pdio_pkg::CTRL_DEFAULT] && unlocked) begin
					dir_next = pdio_pkg::DIR_RST;
					strcfg_next = pdio_pkg::STRCFG_RST;
					opol_next = '0;
					ipol_next = '0;
					rise_next = '0;
					fall_next = '0;
					en_next = '0;
					ctrl_next[7:4] = 4'h0;
				end else if (unlocked || !wdata_i[pdio_pkg::CTRL_LOCK]) begin
					ctrl_next[7:3] = wdata_i[7:3];
				end
			end else if (addr_i == pdio_pkg::ADDR_MON_RISE) begin
				if (unlocked)
					rise_next = wdata_i[ML-1:0];
			end else if (addr_i == pdio_pkg::ADDR_MON_FALL) begin
				if (unlocked)
					fall_next = wdata_i[ML-1:0];
			end else if (addr_i == pdio_pkg::ADDR_MON_EN) begin
				en_next = wdata_i[ML+1:0];
			end else if (addr_i == pdio_pkg::ADDR_MON_EVT) begin
				evt_next = evt_next & ~wdata_i[ML+1:0] | ({stat_hit, hit} &
					{ML+2{state_reg == PDIO_ST_RUN}});
			end
		end

		if (rd_i) begin
			if (addr_i == pdio_pkg::ADDR_DIR) begin
				rdata_next = {27'h0, dir_reg};
			end else if (addr_i >= pdio_pkg::ADDR_OUT_BASE &&
					addr_i < pdio_pkg::ADDR_IN_BASE) begin
				for (int b = 0; b < NB; b++)
					if (addr_i == pdio_pkg::ADDR_OUT_BASE + 8'(b))
						rdata_next = {24'h0, out_reg[b*8 +: 8] ^ opol_reg[b*8 +: 8]};
			end else if (addr_i >= pdio_pkg::ADDR_IN_BASE &&
					addr_i < pdio_pkg::ADDR_OPOL_BASE) begin
				for (int b = 0; b < NB; b++)
					if (addr_i == pdio_pkg::ADDR_IN_BASE + 8'(b))
						rdata_next = {24'h0, io_i[b*8 +: 8] ^ ipol_reg[b*8 +: 8]};
			end else if (addr_i >= pdio_pkg::ADDR_OPOL_BASE &&
					addr_i < pdio_pkg::ADDR_IPOL_BASE) begin
				for (int b = 0; b < NB; b++)
					if (addr_i == pdio_pkg::ADDR_OPOL_BASE + 8'(b))
						rdata_next = {24'h0, opol_reg[b*8 +: 8]};
			end else if (addr_i >= pdio_pkg::ADDR_IPOL_BASE &&
					addr_i < pdio_pkg::ADDR_BITOP) begin
				for (int b = 0; b < NB; b++)
					if (addr_i == pdio_pkg::ADDR_IPOL_BASE + 8'(b))
						rdata_next = {24'h0, ipol_reg[b*8 +: 8]};
			end else if (addr_i == pdio_pkg::ADDR_STR_CFG) begin
				rdata_next = {20'h0, strcfg_reg};
			end else if (addr_i == pdio_pkg::ADDR_STR_IN) begin
				// Sampled fresh on each read; low four string bytes returned packed
				for (int b = 0; b < NB; b++)
					strin_next[b*8 +: 8] = strcfg_reg[5+b] ?
						(io_i[b*8 +: 8] ^ ipol_reg[b*8 +: 8]) : 8'h00;
				if (!strcfg_reg[pdio_pkg::STRCFG_IHS] || hs_ack)
					rdata_next = strin_next[31:0];
			end else if (addr_i == pdio_pkg::ADDR_CTRL) begin
				rdata_next = {24'h0, ctrl_reg[7:3], 3'h0};
			end else if (addr_i == pdio_pkg::ADDR_MON_RISE) begin
				rdata_next = {17'h0, rise_reg};
			end else if (addr_i == pdio_pkg::ADDR_MON_FALL) begin
				rdata_next = {17'h0, fall_reg};
			end else if (addr_i == pdio_pkg::ADDR_MON_EN) begin
				rdata_next = {15'h0, en_reg};
			end else if (addr_i == pdio_pkg::ADDR_MON_COND) begin
				rdata_next = {17'h0, io_i[ML-1:0]};
			end else if (addr_i == pdio_pkg::ADDR_MON_EVT) begin
				rdata_next = {15'h0, evt_reg};
			end else if (addr_i == pdio_pkg::ADDR_OPER) begin
				rdata_next = {30'h0, stat_pin_i};
			end else if (addr_i == pdio_pkg::ADDR_STATUS) begin
				rdata_next = {28'h0, stb_wait_reg, strobe_active, dir_reg != 5'h00,
					settled_reg};
			end
		end

		srq_next = |(evt_next & en_next);
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg <= PDIO_ST_BOOT;
			dir_reg <= pdio_pkg::DIR_RST;
			out_reg <= '0;
			opol_reg <= '0;
			ipol_reg <= '0;
			pulse_mask_reg <= '0;
			pulse_cnt_reg <= 16'h0000;
			strcfg_reg <= pdio_pkg::STRCFG_RST;
			ctrl_reg <= 8'h00;
			stb_cnt_reg <= 16'h0000;
			stb_wait_reg <= 1'b0;
			rise_reg <= '0;
			fall_reg <= '0;
			en_reg <= '0;
			evt_reg <= '0;
			mon_prev_reg <= '0;
			stat_prev_reg <= 2'h0;
			strin_reg <= '0;
			rdata_reg <= 32'h0000_0000;
			settled_reg <= 1'b0;
			srq_reg <= 1'b0;
			nv_save_reg <= 1'b0;
			io_o <= '0;
			io_oe_o <= '0;
			strobe_o <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			dir_reg <= dir_next;
			out_reg <= out_next;
			opol_reg <= opol_next;
			ipol_reg <= ipol_next;
			pulse_mask_reg <= pulse_mask_next;
			pulse_cnt_reg <= pulse_cnt_next;
			strcfg_reg <= strcfg_next;
			ctrl_reg <= ctrl_next;
			stb_cnt_reg <= stb_cnt_next;
			stb_wait_reg <= stb_wait_next;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
			en_reg <= en_next;
			evt_reg <= evt_next;
			mon_prev_reg <= mon_prev_next;
			stat_prev_reg <= stat_prev_next;
			strin_reg <= strin_next;
			rdata_reg <= rdata_next;
			settled_reg <= settled_next;
			srq_reg <= srq_next;
			nv_save_reg <= nv_save_next;
			io_o <= drive_lvl;
			io_oe_o <= drive_oe;
			// Polarity applied at the pin so the counter stays active high
			strobe_o <= strobe_active ^ ctrl_reg[pdio_pkg::CTRL_STB_POL];
		end
	end

	assign rdata_o = rdata_reg;
	assign settled_o = settled_reg;
	assign srq_o = srq_reg;
	assign nv_save_o = nv_save_reg;
	// Save image mirrors the live registers, stable with the save pulse
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			nv_out_o <= '0;
			nv_dir_o <= '0;
		end else if (ce_i) begin
			nv_out_o <= out_reg;
			nv_dir_o <= dir_reg;
		end
	end
endmodule : pdio_port
`default_nettype wire

// >>> pdio_far_side.sv
// Far-side model: line loads with pull-ups and the nonvolatile store
`default_nettype none
module pdio_far_side (
	input wire logic ref_clk_i,
	input wire logic [39:0] io_o_i,
	input wire logic [39:0] io_oe_i,
	input wire logic [39:0] ext_i,
	input wire logic save_i,
	input wire logic [39:0] save_out_i,
	input wire logic [4:0] save_dir_i,
	output logic [39:0] io_i_o,
	output logic [39:0] nv_out_o,
	output logic [4:0] nv_dir_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// A released line follows the outside source, which idles at the pull-up level
	assign io_i_o = (io_oe_i & io_o_i) | (~io_oe_i & ext_i);
	initial begin
		nv_out_o = 40'h00_0000_00A5;
		nv_dir_o = 5'h01;
	end
	always @(posedge ref_clk_i) begin
		if (save_i) begin
			nv_out_o <= save_out_i;
			nv_dir_o <= save_dir_i;
		end
	end
endmodule : pdio_far_side
`default_nettype wire

// >>> pdio_port_chk.sv
// Port assertions for the parallel I/O port
`default_nettype none
module pdio_port_chk (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic self_test_ok_i,
	input wire logic [39:0] io_oe_o,
	input wire logic settled_o,
	input wire logic strobe_o,
	input wire logic nv_save_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	logic wr_ok;
	logic grp_ok;
	assign wr_ok = wr_i && settled_o;
	always_comb begin
		grp_ok = 1'b1;
		for (int b = 0; b < 5; b++) begin
			grp_ok &= (io_oe_o[8*b +: 8] == 8'h00) || (io_oe_o[8*b +: 8] == 8'hFF);
		end
	end
	a_byte_groups: assert property (grp_ok)
		else $error("driver enable split inside a byte");
	a_boot_float: assert property (io_oe_o != 40'h0 |-> settled_o || $past(self_test_ok_i))
		else $error("lines driven before self test");
	a_settle_after: assert property ($rose(settled_o) |-> $past(self_test_ok_i, 2))
		else $error("settled rose too early");
	a_settle_hold: assert property (settled_o |=> settled_o)
		else $error("settled dropped");
	a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside its cycle");
	a_byte_dir: assert property (wr_ok && addr_i == pdio_pkg::ADDR_OUT_BASE
		|-> ##2 io_oe_o[7:0] == 8'hFF)
		else $error("byte write left byte undriven");
	a_bitop_dir: assert property (wr_ok && addr_i == pdio_pkg::ADDR_BITOP
		&& wdata_i[5:3] == 3'h3 && wdata_i[7:6] != 2'h0 |-> ##2 io_oe_o[31:24] == 8'hFF)
		else $error("bit operation left byte undriven");
	a_strobe_go: assert property (wr_ok && addr_i == pdio_pkg::ADDR_CTRL && wdata_i[0]
		&& !wdata_i[4] && !strobe_o |-> ##[1:3] strobe_o)
		else $error("manual strobe missing");
	a_save_go: assert property (wr_ok && addr_i == pdio_pkg::ADDR_CTRL && wdata_i[1]
		|-> ##[1:2] nv_save_o)
		else $error("save pulse missing");
	a_save_pulse: assert property (nv_save_o |=> !nv_save_o)
		else $error("save pulse too long");
endmodule : pdio_port_chk
bind pdio_port pdio_port_chk pdio_port_chk_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.self_test_ok_i(self_test_ok_i), .io_oe_o(io_oe_o), .settled_o(settled_o),
	.strobe_o(strobe_o), .nv_save_o(nv_save_o));
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the parallel I/O port
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic self_test_ok_i = 1'b0;
	logic [1:0] stat_pin_i = 2'h0;
	logic hs_ack = 1'b0;
	logic [39:0] ext = 40'hFF_FFFF_FFFF;
	logic [31:0] rdata_o, rd_val;
	logic [31:0] rng = 32'h05E2;
	logic [39:0] io_i, io_o, io_oe_o, nv_out_i, nv_out_o;
	logic [4:0] nv_dir_i, nv_dir_o;
	logic settled_o, strobe_o, srq_o, nv_save_o;
	logic [7:0] v, p, q;
	int n_fail = 0;
	int checks_done = 0;
	int b, k, n;
	always #10 ref_clk_i = ~ref_clk_i;
	pdio_port pdio_port_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.self_test_ok_i(self_test_ok_i), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o),
		.stat_pin_i(stat_pin_i), .settled_o(settled_o), .strobe_o(strobe_o), .hs_ack_i(hs_ack),
		.srq_o(srq_o), .nv_out_i(nv_out_i), .nv_dir_i(nv_dir_i), .nv_save_o(nv_save_o),
		.nv_out_o(nv_out_o), .nv_dir_o(nv_dir_o));
	pdio_far_side pdio_far_side_inst (.ref_clk_i(ref_clk_i), .io_o_i(io_o), .io_oe_i(io_oe_o),
		.ext_i(ext), .save_i(nv_save_o), .save_out_i(nv_out_o), .save_dir_i(nv_dir_o),
		.io_i_o(io_i), .nv_out_o(nv_out_i), .nv_dir_o(nv_dir_i));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk_i);
		#1;
	endtask : tick
	// A gap cycle between accesses keeps each strobe to one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 rd_val = rdata_o;
	endtask : rd
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		tick(3);
		chk("boot oe", io_oe_o, 40'h0);
		chk("boot settled", settled_o, 1'b0);
		self_test_ok_i <= 1'b1;
		for (k = 0; k < 20 && settled_o !== 1'b1; k++) tick(1);
		chk("settle wait", k < 20, 1'b1);
		if (k == 20) close_out();
		chk("restored oe", io_oe_o, 40'h00_0000_00FF);
		chk("restored out", io_o[7:0], 8'hA5);
		$display("boot test done");
		for (int i = 0; i < 12; i++) begin
			rng = xs(rng);
			b = rng[2:0] % 5;
			{v, p, q} = rng[31:8];
			if (i == 0) begin
				b = 0;
				v = 8'hFF;
			end
			wr(pdio_pkg::ADDR_OPOL_BASE + 8'(b), {24'h0, p});
			wr(pdio_pkg::ADDR_IPOL_BASE + 8'(b), {24'h0, q});
			wr(pdio_pkg::ADDR_OUT_BASE + 8'(b), {24'h0, v});
			tick(3);
			chk("byte out", io_o[8*b +: 8], v ^ p);
			chk("byte oe", io_oe_o[8*b +: 8], 8'hFF);
			rd(pdio_pkg::ADDR_IN_BASE + 8'(b));
			chk("byte in", rd_val[7:0], v ^ p ^ q);
		end
		rd(8'hFF);
		chk("unmapped read", rd_val, 32'h0);
		$display("byte test done");
		wr(pdio_pkg::ADDR_IPOL_BASE, 32'h0);
		wr(pdio_pkg::ADDR_DIR, 32'h4);
		rng = xs(rng);
		ext[7:0] <= rng[7:0];
		tick(3);
		chk("dir oe", io_oe_o, 40'h00_00FF_0000);
		rd(pdio_pkg::ADDR_IN_BASE);
		chk("input byte", rd_val[7:0], rng[7:0]);
		$display("direction test done");
		wr(pdio_pkg::ADDR_MON_RISE, 32'hFFFF);
		wr(pdio_pkg::ADDR_MON_FALL, 32'h0);
		wr(pdio_pkg::ADDR_MON_EN, 32'h20);
		ext[15:0] <= 16'h0000;
		tick(4);
		rd(pdio_pkg::ADDR_MON_EVT);
		tick(1);
		chk("srq idle", srq_o, 1'b0);
		ext[15:0] <= 16'h8020;
		tick(4);
		chk("srq raised", srq_o, 1'b1);
		rd(pdio_pkg::ADDR_MON_COND);
		chk("condition", rd_val[14:0], 15'h0020);
		rd(pdio_pkg::ADDR_MON_EVT);
		chk("events", rd_val[14:0], 15'h0020);
		rd(pdio_pkg::ADDR_MON_EVT);
		chk("events cleared", rd_val[14:0], 15'h0);
		ext[5] <= 1'b0;
		tick(4);
		rd(pdio_pkg::ADDR_MON_EVT);
		chk("fall ignored", rd_val[14:0], 15'h0);
		stat_pin_i <= 2'h1;
		tick(4);
		rd(pdio_pkg::ADDR_MON_EVT);
		chk("pin event", rd_val[16:15], 2'h1);
		rd(pdio_pkg::ADDR_OPER);
		chk("pin level", rd_val[1:0], 2'h1);
		$display("monitor test done");
		wr(pdio_pkg::ADDR_OPOL_BASE + 8'h3, 32'h0);
		wr(pdio_pkg::ADDR_OUT_BASE + 8'h3, 32'h0);
		wr(pdio_pkg::ADDR_BITOP, 32'h5E);
		tick(3);
		chk("bit set", io_o[31:24], 8'h40);
		chk("bit oe", io_oe_o[31:24], 8'hFF);
		wr(pdio_pkg::ADDR_BITOP, 32'h9E);
		tick(3);
		chk("bit clear", io_o[31:24], 8'h00);
		wr(pdio_pkg::ADDR_BITOP, 32'h0080_00DE);
		tick(3);
		chk("pulse on", io_o[31:30], 2'h3);
		tick(2400);
		chk("pulse held", io_o[31:30], 2'h3);
		tick(200);
		chk("pulse off", io_o[31:30], 2'h0);
		$display("bit test done");
		wr(pdio_pkg::ADDR_CTRL, 32'h1);
		for (k = 0; k < 5 && strobe_o !== 1'b1; k++) tick(1);
		for (n = 0; n < 100 && strobe_o === 1'b1; n++) tick(1);
		chk("strobe width", n, pdio_pkg::STROBE_CYC);
		if (k == 5 || n == 100) close_out();
		wr(pdio_pkg::ADDR_CTRL, 32'h2);
		tick(3);
		chk("saved dir", nv_dir_i, 5'h0C);
		chk("saved out", nv_out_i[31:24], 8'h00);
		wr(pdio_pkg::ADDR_CTRL, 32'h8);
		wr(pdio_pkg::ADDR_DIR, 32'h1F);
		tick(3);
		chk("locked dir", io_oe_o, 40'h00_FFFF_0000);
		wr(pdio_pkg::ADDR_CTRL, 32'h0);
		wr(pdio_pkg::ADDR_CTRL, 32'h4);
		tick(3);
		chk("default dir", io_oe_o, 40'h0);
		$display("control test done");
		rng = xs(rng);
		ext[7:0] <= rng[7:0];
		wr(pdio_pkg::ADDR_DIR, 32'h2);
		wr(pdio_pkg::ADDR_STR_CFG, 32'h022);
		wr(pdio_pkg::ADDR_STR_OUT, rng);
		tick(2);
		chk("string out", io_o[15:8], rng[15:8]);
		chk("string strobe", strobe_o, 1'b1);
		tick(60);
		chk("plain strobe end", strobe_o, 1'b0);
		v = ~rng[15:8];
		wr(pdio_pkg::ADDR_STR_CFG, 32'hC22);
		wr(pdio_pkg::ADDR_STR_OUT, ~rng);
		tick(60);
		chk("held strobe", strobe_o, 1'b1);
		chk("held out", io_o[15:8], v);
		hs_ack <= 1'b1;
		tick(3);
		chk("acked strobe", strobe_o, 1'b0);
		rd(pdio_pkg::ADDR_STR_IN);
		chk("string in ack", rd_val, {24'h0, rng[7:0]});
		hs_ack <= 1'b0;
		rd(pdio_pkg::ADDR_STR_IN);
		chk("string in wait", rd_val, 32'h0);
		wr(pdio_pkg::ADDR_STR_CFG, 32'h022);
		wr(pdio_pkg::ADDR_CTRL, 32'h40);
		rng = xs(rng);
		wr(pdio_pkg::ADDR_STR_OUT, {1'b0, rng[30:0]});
		tick(3);
		chk("word pending", strobe_o, 1'b0);
		chk("word byte", io_o[15:8], rng[15:8]);
		wr(pdio_pkg::ADDR_STR_OUT, {1'b1, rng[30:0]});
		tick(2);
		chk("word strobe", strobe_o, 1'b1);
		ext[7:0] <= rng[23:16];
		tick(1);
		rd(pdio_pkg::ADDR_STR_IN);
		chk("fresh sample", rd_val, {24'h0, rng[23:16]});
		tick(60);
		wr(pdio_pkg::ADDR_CTRL, 32'h30);
		wr(pdio_pkg::ADDR_STR_CFG, 32'h822);
		tick(2);
		chk("strobe idle pol", strobe_o, 1'b1);
		rd(pdio_pkg::ADDR_STR_IN);
		chk("ack pol", rd_val, {24'h0, rng[23:16]});
		$display("string test done");
		close_out();
	end
endmodule : tb
`default_nettype wire
